/* hw/sdc_checker.sv */
// Contract
// - Limit is the two limit pieces joined into twenty bits before checks.
// - Scale flag clear counts limit in bytes, set counts 4-KByte units.
// - With scale set, low twelve offset bits are ignored in limit checks.
// - Expand-up accepts offsets zero to limit, faults above it.
// - Expand-down accepts limit to upper bound, faults below limit.
// - Expand-down upper bound is 4 GBytes with size flag set, else 64 KBytes.
// - Base is three pieces joined into one 32-bit linear base.
// - Base stays byte granular; only the limit is scaled.
// - Class flag clear means system descriptor, set means code or data.
// - Type bit 11 selects data when clear, code when set.
// - Data type bits 8, 9, 10 are accessed, write-enable, expand-down.
// - Two-bit privilege field, 0 most privileged, carried for access control.
// - Loading a descriptor with present clear raises a not-present fault.
// - With present clear, available locations are never relied upon.
// - Code size flag set gives 32-bit default addresses, clear gives 16-bit.
// - Stack size flag set uses the wide stack pointer, clear the narrow.
// - Stack load of a data segment without write permission faults.
// - Every successful load sets the descriptor accessed bit.
// - Accessed bit is written back only when not already set.
// - Code type bits are accessed, read-enable, conforming; code never writable.
// - Null selector loaded into code or stack register raises protection fault.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sdc_checker (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    // AXI4-Lite write address.
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    // AXI4-Lite write data.
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response.
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address.
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    // AXI4-Lite read data.
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Fault, accessed write-back and size indications to the processor.
    output logic protection_fault,
    output logic not_present_fault,
    output logic acc_wb_valid,
    output logic [31:0] acc_wb_data,
    output logic [15:0] acc_wb_selector,
    output logic wide_addr,
    output logic wide_stack_pointer_sel
);
    // Pulls each used field from its fixed position in the two doublewords; the available bit is not decoded.
    function automatic sdc_pkg::sdc_desc_s decode(input logic [31:0] lo, input logic [31:0] hi);
        sdc_pkg::sdc_desc_s d;
        d.base = {hi[sdc_pkg::HI_BASE_TOP_LSB +: 8], hi[sdc_pkg::HI_BASE_MID_LSB +: 8],
                  lo[sdc_pkg::LO_BASE_LSB +: 16]};
        d.limit = {hi[sdc_pkg::HI_LIMIT_LSB +: 4], lo[sdc_pkg::LO_LIMIT_LSB +: 16]};
        d.seg_type = hi[sdc_pkg::HI_TYPE_LSB +: 4];
        d.code_data = hi[sdc_pkg::HI_CLASS];
        d.descriptor_privilege = hi[sdc_pkg::HI_PRIV_LSB +: 2];
        d.present = hi[sdc_pkg::HI_PRESENT];
        d.dsize = hi[sdc_pkg::HI_DSIZE];
        d.scale = hi[sdc_pkg::HI_SCALE];
        return d;
    endfunction : decode

    // Effective byte limit; only the limit is scaled, never the base.
    function automatic logic [31:0] eff_limit(input sdc_pkg::sdc_desc_s d);
        if (d.scale) begin
            return {d.limit, sdc_pkg::SCALE_FILL};
        end
        return {12'h000, d.limit};
    endfunction : eff_limit

    // Byte-lane merge of a write into an existing word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic aw_got_ff, w_got_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic [31:0] desc_lo_ff, desc_hi_ff, load_ctrl_ff, offset_ff;
    logic [31:0] linear_ff, wb_hi_ff;
    sdc_pkg::sdc_desc_s cache_ff;
    logic cache_valid_ff, cache_null_ff;
    sdc_pkg::sdc_seg_e cache_seg_ff;
    sdc_pkg::sdc_result_s res_ff;
    logic prot_ff, absent_ff, wb_valid_ff, wide_addr_ff, wide_stack_ff;
    logic [15:0] wb_sel_ff;

    // Write channel bookkeeping.
    logic aw_hs, w_hs, aw_have, w_have, do_write;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic nxt_aw_got, nxt_w_got, nxt_bvalid, wr_hit, load_go, chk_go;
    assign aw_hs = s_axi_awvalid & awready_ff;
    assign w_hs = s_axi_wvalid & wready_ff;
    assign aw_have = aw_got_ff | aw_hs;
    assign w_have = w_got_ff | w_hs;
    assign do_write = aw_have & w_have & ~bvalid_ff;
    assign wr_addr = aw_got_ff ? aw_addr_ff : s_axi_awaddr;
    assign wr_data = w_got_ff ? w_data_ff : s_axi_wdata;
    assign wr_strb = w_got_ff ? w_strb_ff : s_axi_wstrb;
    assign nxt_aw_got = aw_have & ~do_write;
    assign nxt_w_got = w_have & ~do_write;
    assign nxt_bvalid = do_write | (bvalid_ff & ~s_axi_bready);
    assign wr_hit = (wr_addr == sdc_pkg::ADDR_DESC_LO) | (wr_addr == sdc_pkg::ADDR_DESC_HI)
                  | (wr_addr == sdc_pkg::ADDR_LOAD) | (wr_addr == sdc_pkg::ADDR_OFFSET);
    assign load_go = do_write & (wr_addr == sdc_pkg::ADDR_LOAD);
    assign chk_go = do_write & (wr_addr == sdc_pkg::ADDR_OFFSET);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= sdc_pkg::RESP_OKAY;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
            wready_ff <= ~nxt_w_got & ~nxt_bvalid;
            bvalid_ff <= nxt_bvalid;
            if (aw_hs) begin
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                bresp_ff <= wr_hit ? sdc_pkg::RESP_OKAY : sdc_pkg::RESP_SLVERR;
            end
        end
    end

    // Software-written registers.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            desc_lo_ff <= 32'h00000000;
            desc_hi_ff <= 32'h00000000;
            load_ctrl_ff <= 32'h00000000;
            offset_ff <= 32'h00000000;
        end else if (do_write) begin
            case (wr_addr)
                sdc_pkg::ADDR_DESC_LO: desc_lo_ff <= merge(desc_lo_ff, wr_data, wr_strb);
                sdc_pkg::ADDR_DESC_HI: desc_hi_ff <= merge(desc_hi_ff, wr_data, wr_strb);
                sdc_pkg::ADDR_LOAD: load_ctrl_ff <= merge(load_ctrl_ff, wr_data, wr_strb);
                sdc_pkg::ADDR_OFFSET: offset_ff <= merge(offset_ff, wr_data, wr_strb);
                default: desc_lo_ff <= desc_lo_ff;
            endcase
        end
    end

    // Segment load evaluation, based on the load word being written this cycle and the stored descriptor.
    logic [31:0] ld_word;
    logic [15:0] ld_sel;
    sdc_pkg::sdc_seg_e ld_seg;
    sdc_pkg::sdc_desc_s ld_desc;
    logic ld_null, ld_prot, ld_absent, ld_code, ld_ok;
    assign ld_word = merge(load_ctrl_ff, wr_data, wr_strb);
    assign ld_sel = ld_word[sdc_pkg::LD_SEL_LSB +: 16];
    assign ld_seg = sdc_pkg::sdc_seg_e'(ld_word[sdc_pkg::LD_SEG_LSB +: 3]);
    assign ld_desc = decode(desc_lo_ff, desc_hi_ff);
    assign ld_null = (ld_sel[15:sdc_pkg::SEL_INDEX_LSB] == 13'h0000)
                   & ~ld_sel[sdc_pkg::SEL_TABLE_BIT];
    assign ld_code = ld_desc.seg_type[sdc_pkg::TY_CODE];

    always_comb begin
        ld_prot = 1'b0;
        ld_absent = 1'b0;
        if (ld_null) begin
            // Null into a data register is legal; the fault waits for use.
            ld_prot = (ld_seg == sdc_pkg::SEG_CS) | (ld_seg == sdc_pkg::SEG_SS);
        end else if (!ld_desc.code_data) begin
            // Gates and system segments are not handled here and are refused.
            ld_prot = 1'b1;
        end else if (ld_seg == sdc_pkg::SEG_SS) begin
            ld_prot = ld_code | ~ld_desc.seg_type[sdc_pkg::TY_WR_RD];
        end else if (ld_seg == sdc_pkg::SEG_CS) begin
            ld_prot = ~ld_code;
        end else if (ld_code) begin
            // Data registers may hold code only when it is readable.
            ld_prot = ~ld_desc.seg_type[sdc_pkg::TY_WR_RD];
        end
        if (!ld_prot && !ld_null && !ld_desc.present) begin
            ld_absent = 1'b1;
        end
    end
    assign ld_ok = ~ld_prot & ~ld_absent;

    // Cached hidden part. On a non-present descriptor nothing is cached, so the
    // software-owned locations never reach any decision.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cache_ff <= '0;
            cache_valid_ff <= 1'b0;
            cache_null_ff <= 1'b0;
            cache_seg_ff <= sdc_pkg::SEG_ES;
        end else if (load_go) begin
            cache_valid_ff <= ld_ok;
            cache_null_ff <= ld_null;
            cache_seg_ff <= ld_seg;
            if (ld_ok && !ld_null) begin
                cache_ff <= ld_desc;
                cache_ff.seg_type[sdc_pkg::TY_ACC] <= 1'b1;
            end
        end
    end

    // Accessed bit write-back, only for descriptors not yet marked.
    logic need_wb;
    assign need_wb = load_go & ld_ok & ~ld_null & ~desc_hi_ff[sdc_pkg::HI_ACCESSED];
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wb_valid_ff <= 1'b0;
            wb_hi_ff <= 32'h00000000;
            wb_sel_ff <= 16'h0000;
        end else begin
            wb_valid_ff <= need_wb;
            if (need_wb) begin
                wb_hi_ff <= desc_hi_ff | (32'h00000001 << sdc_pkg::HI_ACCESSED);
                wb_sel_ff <= ld_sel;
            end
        end
    end

    // Offset check against the cached descriptor.
    logic [31:0] chk_off, lim, bound;
    logic chk_expdown, chk_below, chk_above, chk_prot;
    assign chk_off = merge(offset_ff, wr_data, wr_strb);
    assign lim = eff_limit(cache_ff);
    assign chk_expdown = ~cache_ff.seg_type[sdc_pkg::TY_CODE]
                       & cache_ff.seg_type[sdc_pkg::TY_EXP_CONF];
    assign bound = cache_ff.dsize ? sdc_pkg::BOUND_WIDE : sdc_pkg::BOUND_NARROW;
    // With scaling set only the upper offset bits take part in the test.
    assign chk_above = cache_ff.scale ? (chk_off[31:sdc_pkg::SCALE_SHIFT] > cache_ff.limit)
                                      : (chk_off > lim);
    assign chk_below = cache_ff.scale ? (chk_off[31:sdc_pkg::SCALE_SHIFT] < cache_ff.limit)
                                      : (chk_off < lim);
    assign chk_prot = ~cache_valid_ff | cache_null_ff
                    | (chk_expdown ? (chk_below | (chk_off > bound)) : chk_above);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            res_ff <= '0;
            linear_ff <= 32'h00000000;
        end else if (load_go) begin
            res_ff.load_done <= 1'b1;
            res_ff.load_prot <= ld_prot;
            res_ff.load_absent <= ld_absent;
            res_ff.acc_wb <= need_wb;
        end else if (chk_go) begin
            res_ff.check_prot <= chk_prot;
            linear_ff <= cache_ff.base + chk_off;
        end
    end

    // Fault pulses and size selections toward the processor.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prot_ff <= 1'b0;
            absent_ff <= 1'b0;
            wide_addr_ff <= 1'b0;
            wide_stack_ff <= 1'b0;
        end else begin
            prot_ff <= (load_go & ld_prot) | (chk_go & chk_prot);
            absent_ff <= load_go & ld_absent;
            if (load_go && ld_ok && !ld_null) begin
                if (ld_seg == sdc_pkg::SEG_CS) begin
                    wide_addr_ff <= ld_desc.dsize;
                end
                if (ld_seg == sdc_pkg::SEG_SS) begin
                    wide_stack_ff <= ld_desc.dsize;
                end
            end
        end
    end

    // Read channel; one cycle from address to data.
    logic [31:0] status_word, rd_word;
    logic [3:0] cty;
    logic rd_hit;
    assign cty = cache_ff.seg_type;
    assign status_word = {11'h000, cache_seg_ff, cache_null_ff, ~cache_ff.code_data,
                          cache_ff.descriptor_privilege, cache_ff.scale, wide_stack_ff,
                          wide_addr_ff, cty[sdc_pkg::TY_CODE] & cty[sdc_pkg::TY_EXP_CONF],
                          cty[sdc_pkg::TY_CODE] & cty[sdc_pkg::TY_WR_RD],
                          ~cty[sdc_pkg::TY_CODE] & cty[sdc_pkg::TY_WR_RD],
                          chk_expdown, cty[sdc_pkg::TY_CODE], cache_valid_ff,
                          res_ff.acc_wb, res_ff.check_prot, res_ff.load_absent, res_ff.load_prot,
                          res_ff.load_done};

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            sdc_pkg::ADDR_DESC_LO: rd_word = desc_lo_ff;
            sdc_pkg::ADDR_DESC_HI: rd_word = desc_hi_ff;
            sdc_pkg::ADDR_LOAD: rd_word = load_ctrl_ff;
            sdc_pkg::ADDR_OFFSET: rd_word = offset_ff;
            sdc_pkg::ADDR_STATUS: rd_word = status_word;
            sdc_pkg::ADDR_BASE: rd_word = cache_ff.base;
            sdc_pkg::ADDR_LIMIT: rd_word = lim;
            sdc_pkg::ADDR_LINEAR: rd_word = linear_ff;
            sdc_pkg::ADDR_WB_HI: rd_word = wb_hi_ff;
            default: begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    logic ar_hs, nxt_rvalid;
    assign ar_hs = s_axi_arvalid & arready_ff;
    assign nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= sdc_pkg::RESP_OKAY;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_hs) begin
                rdata_ff <= rd_word;
                rresp_ff <= rd_hit ? sdc_pkg::RESP_OKAY : sdc_pkg::RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign protection_fault = prot_ff;
    assign not_present_fault = absent_ff;
    assign acc_wb_valid = wb_valid_ff;
    assign acc_wb_data = wb_hi_ff;
    assign acc_wb_selector = wb_sel_ff;
    assign wide_addr = wide_addr_ff;
    assign wide_stack_pointer_sel = wide_stack_ff;
endmodule : sdc_checker
`default_nettype wire

/* inc/sdc_pkg.sv */
`default_nettype none
package sdc_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADDR_DESC_LO = 8'h00;
    localparam logic [7:0] ADDR_DESC_HI = 8'h04;
    localparam logic [7:0] ADDR_LOAD = 8'h08;
    localparam logic [7:0] ADDR_OFFSET = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_BASE = 8'h14;
    localparam logic [7:0] ADDR_LIMIT = 8'h18;
    localparam logic [7:0] ADDR_LINEAR = 8'h1C;
    localparam logic [7:0] ADDR_WB_HI = 8'h20;
    localparam int ADDR_W = 8;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Descriptor field positions, second doubleword.
    localparam int HI_BASE_MID_LSB = 0;
    localparam int HI_TYPE_LSB = 8;
    localparam int HI_ACCESSED = 8;
    localparam int HI_CLASS = 12;
    localparam int HI_PRIV_LSB = 13;
    localparam int HI_PRESENT = 15;
    localparam int HI_LIMIT_LSB = 16;
    localparam int HI_AVAIL = 20;
    localparam int HI_DSIZE = 22;
    localparam int HI_SCALE = 23;
    localparam int HI_BASE_TOP_LSB = 24;
    // Descriptor field positions, first doubleword.
    localparam int LO_LIMIT_LSB = 0;
    localparam int LO_BASE_LSB = 16;

    // Type field bits for code and data descriptors.
    localparam int TY_ACC = 0;
    localparam int TY_WR_RD = 1;
    localparam int TY_EXP_CONF = 2;
    localparam int TY_CODE = 3;

    // Load control layout.
    localparam int LD_SEL_LSB = 0;
    localparam int LD_SEG_LSB = 16;
    localparam int SEL_TABLE_BIT = 2;
    localparam int SEL_INDEX_LSB = 3;

    // Limit scaling and upper bounds.
    localparam int SCALE_SHIFT = 12;
    localparam logic [11:0] SCALE_FILL = 12'hFFF;
    localparam logic [31:0] BOUND_WIDE = 32'hFFFFFFFF;
    localparam logic [31:0] BOUND_NARROW = 32'h0000FFFF;

    typedef enum logic [2:0] {
        SEG_ES, SEG_CS, SEG_SS, SEG_DS, SEG_FS, SEG_GS
    } sdc_seg_e;

    typedef struct packed {
        logic [31:0] base;
        logic [19:0] limit;
        logic [3:0] seg_type;
        logic code_data;
        logic [1:0] descriptor_privilege;
        logic present;
        logic dsize;
        logic scale;
    } sdc_desc_s;

    typedef struct packed {
        logic load_done;
        logic load_prot;
        logic load_absent;
        logic check_prot;
        logic acc_wb;
    } sdc_result_s;
endpackage : sdc_pkg
`default_nettype wire

/* bench/sdc_checker_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sdc_checker_chk (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    // Bus handshakes.
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Segment results.
    input wire logic protection_fault,
    input wire logic not_present_fault,
    input wire logic acc_wb_valid,
    input wire logic [31:0] acc_wb_data,
    input wire logic wide_addr,
    input wire logic wide_stack_pointer_sel
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_fault_pulse: assert property (
        protection_fault |-> $rose(s_axi_bvalid) ##1 !protection_fault)
        else $error("protection fault not a pulse with the response");
    a_absent_fault: assert property (
        not_present_fault |-> $rose(s_axi_bvalid) && !protection_fault && !acc_wb_valid)
        else $error("not present fault out of place");
    a_accessed_wb: assert property (
        acc_wb_valid |-> $rose(s_axi_bvalid) && acc_wb_data[8])
        else $error("write-back without accessed bit or response");
    a_wb_word_held: assert property ($changed(acc_wb_data) |-> acc_wb_valid)
        else $error("write-back word moved without a write-back");
    a_size_moves: assert property (
        $changed(wide_addr) || $changed(wide_stack_pointer_sel) |-> $rose(s_axi_bvalid))
        else $error("size flag moved outside a load");

    c_prot: cover property (protection_fault);
    c_absent: cover property (not_present_fault);
    c_wb: cover property (acc_wb_valid);
endmodule : sdc_checker_chk

bind sdc_checker sdc_checker_chk i_sdc_checker_chk (.clk_sys, .reset_n, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .protection_fault,
    .not_present_fault, .acc_wb_valid, .acc_wb_data, .wide_addr, .wide_stack_pointer_sel);
`default_nettype wire

/* bench/sdc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sdc_host (
    // Clock.
    input wire logic clk_sys,
    // Requests towards the checker.
    output var logic s_axi_awvalid,
    output var logic [7:0] s_axi_awaddr,
    output var logic s_axi_wvalid,
    output var logic [31:0] s_axi_wdata,
    output var logic s_axi_bready,
    output var logic s_axi_arvalid,
    output var logic [7:0] s_axi_araddr,
    output var logic s_axi_rready,
    // Answers from the checker.
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    initial {s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata, s_axi_bready,
             s_axi_arvalid, s_axi_araddr, s_axi_rready} = '0;

    // Released payloads are inverted so a slave that samples them late sees wrong data.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : sdc_host
`default_nettype wire

/* bench/test_segment_descriptor_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module test_segment_descriptor_checker;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic protection_fault, not_present_fault, acc_wb_valid, wide_addr, wide_stack_pointer_sel;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, acc_wb_data, lo, hi, got, base, q, e;
    logic [31:0] offs [7];
    logic [19:0] m;
    logic [15:0] acc_wb_selector, sel;
    logic [2:0] seg, x;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic ok, up, wa = 1'b0, ws = 1'b0;
    int n_errors = 0, comparisons = 0;
    int seed = 32'h70f6;

    sdc_checker i_sdc_checker (.clk_sys, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .protection_fault, .not_present_fault,
        .acc_wb_valid, .acc_wb_data, .acc_wb_selector, .wide_addr, .wide_stack_pointer_sel);
    sdc_host i_sdc_host (.clk_sys, .s_axi_awvalid, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wdata,
        .s_axi_bready, .s_axi_arvalid, .s_axi_araddr, .s_axi_rready, .s_axi_awready,
        .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata);

    always #2 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] g, input logic [31:0] v, input string s);
        comparisons++;
        if (g !== v) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, s, g, v);
        end
    endtask : chk

    task automatic test_done();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // Outcome of a load as {protection, not present, write-back}, in load evaluation order.
    function automatic logic [2:0] exp_load(logic [31:0] h, logic [15:0] s, logic [2:0] g);
        logic cs, ss;
        cs = g == sdc_pkg::SEG_CS;
        ss = g == sdc_pkg::SEG_SS;
        if (s[15:2] == 14'h0) return {cs || ss, 2'h0};
        if (!h[12]) return 3'h4;
        if (ss && (h[11] || !h[9])) return 3'h4;
        if (cs && !h[11]) return 3'h4;
        if (!cs && !ss && h[11] && !h[9]) return 3'h4;
        if (!h[15]) return 3'h2;
        return {2'h0, !h[8]};
    endfunction : exp_load

    function automatic logic exp_fault(logic [19:0] n, logic [31:0] h, logic [31:0] o);
        logic [31:0] b;
        b = h[22] ? sdc_pkg::BOUND_WIDE : sdc_pkg::BOUND_NARROW;
        if (h[11] || !h[10]) return h[23] ? o[31:12] > n : o > {12'h0, n};
        return (h[23] ? o[31:12] < n : o < {12'h0, n}) || o > b;
    endfunction : exp_fault

    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        i_sdc_host.wr(8'h40, 32'h0, r);
        chk(32'(r), 32'(sdc_pkg::RESP_SLVERR), "unmapped write");
        i_sdc_host.wr(sdc_pkg::ADDR_STATUS, 32'h0, r);
        chk(32'(r), 32'(sdc_pkg::RESP_SLVERR), "read-only write");
        i_sdc_host.rd(8'h40, got);
        chk(got, 32'h0, "unmapped read");
        chk(32'(s_axi_rresp), 32'(sdc_pkg::RESP_SLVERR), "unmapped read response");
        for (int i = 0; i < 90; i++) begin
            lo = $random(seed);
            hi = $random(seed) & 32'hFFDFFFFF;
            hi[12] = i % 8 != 0;
            hi[15] = i % 8 != 1;
            sel = i % 7 == 2 ? 16'h0 : 16'($random(seed));
            seg = 3'(i % 6);
            i_sdc_host.wr(sdc_pkg::ADDR_DESC_LO, lo, r);
            i_sdc_host.wr(sdc_pkg::ADDR_DESC_HI, hi, r);
            i_sdc_host.wr(sdc_pkg::ADDR_LOAD, {13'h0, seg, sel}, r);
            i_sdc_host.rd(sdc_pkg::ADDR_STATUS, got);
            x = exp_load(hi, sel, seg);
            chk(32'({got[1], got[2], got[4]}), 32'(x), "load");
            ok = x[2:1] == 2'h0 && sel[15:2] != 14'h0;
            if (ok && seg == sdc_pkg::SEG_CS) wa = hi[22];
            if (ok && seg == sdc_pkg::SEG_SS) ws = hi[22];
            chk(32'(wide_addr), 32'(wa), "code size");
            chk(32'(wide_stack_pointer_sel), 32'(ws), "stack size");
            m = {hi[19:16], lo[15:0]};
            up = hi[11] || !hi[10];
            base = {hi[31:24], hi[7:0], lo[31:16]};
            q = hi[23] ? {m, 12'h000} : {12'h0, m};
            e = hi[23] ? {m, 12'hFFF} : {12'h0, m};
            if (ok) begin
                if (x[0]) chk(acc_wb_data, hi | 32'h100, "write-back");
                if (x[0]) chk(32'(acc_wb_selector), 32'(sel), "selector");
                i_sdc_host.rd(sdc_pkg::ADDR_BASE, got);
                chk(got, base, "base");
                i_sdc_host.rd(sdc_pkg::ADDR_STATUS, got);
                chk(32'({got[16:13], got[8:6]}),
                    32'({1'b0, hi[14:13], hi[23], !hi[11] && hi[9], !up, hi[11]}), "status");
                i_sdc_host.rd(sdc_pkg::ADDR_LIMIT, got);
                if (up) chk(got, e, "limit");
            end
            offs = '{q - 32'h1, q, e, e + 32'h1, 32'hFFFF, 32'h10000, $random(seed)};
            foreach (offs[k]) begin
                i_sdc_host.wr(sdc_pkg::ADDR_OFFSET, offs[k], r);
                i_sdc_host.rd(sdc_pkg::ADDR_STATUS, got);
                x[2] = !ok || exp_fault(m, hi, offs[k]);
                chk(32'(got[3]), 32'(x[2]), "offset");
                i_sdc_host.rd(sdc_pkg::ADDR_LINEAR, got);
                if (!x[2]) chk(got, base + offs[k], "linear");
            end
        end
        test_done();
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        test_done();
    end
endmodule : test_segment_descriptor_checker
`default_nettype wire
